// file: logic/mezz_status_map.svh
`ifndef MEZZ_STATUS_MAP_SVH
`define MEZZ_STATUS_MAP_SVH

// ****************************************
// Clock and timing
// ****************************************
`define CLK_MHZ            100
`define RST_MIN_LOW_US     1000
`define RST_MIN_LOW_CYCLES (`RST_MIN_LOW_US * `CLK_MHZ)
`define ACT_BLINK_MS       50
`define ACT_BLINK_CYCLES   (`ACT_BLINK_MS * 1000 * `CLK_MHZ)
`define LONG_HOLD_MS       5000
`define LONG_HOLD_CYCLES   (`LONG_HOLD_MS * 1000 * `CLK_MHZ)
`define CNT_W              32

// ****************************************
// Link speed codes and widths
// ****************************************
`define SPEED_CODE_10      2'h0
`define SPEED_CODE_100     2'h1
`define SPEED_CODE_1000    2'h2
`define GPIO_COUNT         96

`endif

// file: logic/mezz_status_pkg.sv
package mezz_status_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_HELD,
    ST_MIN_LOW,
    ST_RUN
  } rst_state_t;

  typedef enum logic {
    RESET_KIND_SHORT,
    RESET_KIND_LONG
  } reset_kind_t;

endpackage

// file: logic/mezzanine_status_reset_signals.sv
`timescale 1ns/100ps
`include "mezz_status_map.svh"

module mezzanine_status_reset_signals #(
  parameter int unsigned RST_MIN_CYCLES   = `RST_MIN_LOW_CYCLES,
  parameter int unsigned BLINK_CYCLES     = `ACT_BLINK_CYCLES,
  parameter int unsigned LONG_HOLD_CYCLES = `LONG_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic                          clk_sys_in,
  input  wire logic                          arst_n_in,
  // Supply and connector reset
  input  wire logic                          power_good_in,
  input  wire logic                          system_reset_in_n_in,
  // Ethernet status from the PHY side
  input  wire logic                          link_up_in,
  input  wire logic                          link_traffic_in,
  input  wire logic [1:0]                    link_speed_in,
  // Configuration state
  input  wire logic                          logic_configured_in,
  // User drive and sampled levels of the general purpose lines
  input  wire logic [`GPIO_COUNT-1:0]        gpio_drive_value_in,
  input  wire logic [`GPIO_COUNT-1:0]        gpio_drive_use_in,
  input  wire logic [`GPIO_COUNT-1:0]        general_purpose_io_lines_in,
  // Indicators
  output logic                               link_activity_indicator_out,
  output logic                               speed_indicator_green_out,
  output logic                               speed_indicator_yellow_out,
  // Resets
  output logic                               reset_indication_n_out,
  output logic                               core_reset_n_out,
  output mezz_status_pkg::reset_kind_t       reset_kind_out,
  output logic                               reset_kind_valid_out,
  // Configuration and lines
  output logic                               logic_configured_flag_out,
  output logic [`GPIO_COUNT-1:0]             general_purpose_io_lines_out,
  output logic [`GPIO_COUNT-1:0]             general_purpose_io_lines_oe_n_out,
  output logic [`GPIO_COUNT-1:0]             gpio_sample_out
);

  // ****************************************
  // System reset synchroniser
  // ****************************************
  logic                         sys_sync_meta;
  logic                         sys_sync_q;
  logic                         sys_sync_d;

  // two flop sync
  // Reset to idle high, else a false release follows every reset
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sys_sync_meta <= 1'b1;
      sys_sync_q    <= 1'b1;
      sys_sync_d    <= 1'b1;
    end else begin
      sys_sync_meta <= system_reset_in_n_in;
      sys_sync_q    <= sys_sync_meta;
      sys_sync_d    <= sys_sync_q;
    end
  end

  wire                          system_reset_in_n_active = ~sys_sync_q;
  wire                          sys_released   = sys_sync_q & ~sys_sync_d;
  wire                          reset_cause    = system_reset_in_n_active |
                                                 ~power_good_in;

  // ****************************************
  // Reset sequencing
  // ****************************************
  mezz_status_pkg::rst_state_t  state_q;
  mezz_status_pkg::rst_state_t  next_state;
  logic [`CNT_W-1:0]            low_cnt;
  logic [`CNT_W-1:0]            hold_cnt;

  wire                          low_done = low_cnt >=
                                           `CNT_W'(RST_MIN_CYCLES - 1);
  wire [`CNT_W-1:0]             next_low_cnt =
    (state_q == mezz_status_pkg::ST_RUN) ? '0 :
    (&low_cnt) ? low_cnt : low_cnt + `CNT_W'(1);
  wire [`CNT_W-1:0]             next_hold_cnt =
    !system_reset_in_n_active ? '0 :
    (&hold_cnt) ? hold_cnt : hold_cnt + `CNT_W'(1);
  wire                          hold_long = hold_cnt >=
                                            `CNT_W'(LONG_HOLD_CYCLES);
  wire mezz_status_pkg::reset_kind_t next_kind =
    hold_long ? mezz_status_pkg::RESET_KIND_LONG :
                mezz_status_pkg::RESET_KIND_SHORT;

  always_comb begin
    next_state = state_q;
    unique case (state_q)
      mezz_status_pkg::ST_HELD: begin
        if (!reset_cause) begin
          next_state = mezz_status_pkg::ST_MIN_LOW;
        end
      end
      mezz_status_pkg::ST_MIN_LOW: begin
        if (low_done) begin
          next_state = mezz_status_pkg::ST_RUN;
        end
      end
      mezz_status_pkg::ST_RUN: begin
        next_state = mezz_status_pkg::ST_RUN;
      end
      default: begin
        next_state = mezz_status_pkg::ST_HELD;
      end
    endcase
    if (reset_cause) begin
      next_state = mezz_status_pkg::ST_HELD;
    end
  end

  wire                          next_running =
                                  next_state == mezz_status_pkg::ST_RUN;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q  <= mezz_status_pkg::ST_HELD;
      low_cnt  <= '0;
      hold_cnt <= '0;
    end else begin
      state_q  <= next_state;
      low_cnt  <= next_low_cnt;
      hold_cnt <= next_hold_cnt;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reset_indication_n_out <= 1'b0;
      core_reset_n_out       <= 1'b0;
    end else begin
      reset_indication_n_out <= next_running;
      core_reset_n_out       <= next_running;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reset_kind_out       <= mezz_status_pkg::RESET_KIND_SHORT;
      reset_kind_valid_out <= 1'b0;
    end else begin
      reset_kind_valid_out <= sys_released;
      if (sys_released) begin
        reset_kind_out <= next_kind;
      end
    end
  end

  // ****************************************
  // Ethernet indicators
  // ****************************************
  logic [`CNT_W-1:0]            blink_cnt;
  logic                         traffic_seen;

  // Traffic is folded per blink period so short bursts still show
  wire                          blink_tick = blink_cnt >=
                                             `CNT_W'(BLINK_CYCLES - 1);
  wire [`CNT_W-1:0]             next_blink_cnt =
    blink_tick ? '0 : blink_cnt + `CNT_W'(1);
  // Set wins over the period clear
  wire                          next_traffic_seen =
    link_traffic_in | (traffic_seen & ~blink_tick);
  wire                          next_activity =
    !link_up_in  ? 1'b0 :
    traffic_seen ? (link_activity_indicator_out ^ blink_tick) : 1'b1;
  wire                          next_green =
    link_up_in & (link_speed_in == `SPEED_CODE_100);
  wire                          next_yellow =
    link_up_in & (link_speed_in == `SPEED_CODE_1000);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      blink_cnt                   <= '0;
      traffic_seen                <= 1'b0;
      link_activity_indicator_out <= 1'b0;
      speed_indicator_green_out   <= 1'b0;
      speed_indicator_yellow_out  <= 1'b0;
    end else begin
      blink_cnt                   <= next_blink_cnt;
      traffic_seen                <= next_traffic_seen;
      link_activity_indicator_out <= next_activity;
      speed_indicator_green_out   <= next_green;
      speed_indicator_yellow_out  <= next_yellow;
    end
  end

  // ****************************************
  // Configuration and general purpose lines
  // ****************************************
  // Lines also float during board reset; safer than a stale drive
  wire                          drive_allowed = logic_configured_in &
                                                next_running;
  wire [`GPIO_COUNT-1:0]        next_oe_n =
    ~(gpio_drive_use_in & {`GPIO_COUNT{drive_allowed}});

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      logic_configured_flag_out         <= 1'b0;
      general_purpose_io_lines_out      <= '0;
      general_purpose_io_lines_oe_n_out <= '1;
      gpio_sample_out                   <= '0;
    end else begin
      logic_configured_flag_out         <= logic_configured_in;
      general_purpose_io_lines_out      <= gpio_drive_value_in;
      general_purpose_io_lines_oe_n_out <= next_oe_n;
      gpio_sample_out                   <= general_purpose_io_lines_in;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  logic [`CNT_W-1:0]            ind_low_len;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ind_low_len <= '0;
    end else if (!reset_indication_n_out) begin
      ind_low_len <= ind_low_len + `CNT_W'(1);
    end else begin
      ind_low_len <= '0;
    end
  end

  a_act_no_link: assert property (
    !link_up_in |=> !link_activity_indicator_out)
    else $error("activity high without link");

  a_act_idle_high: assert property (
    link_up_in && !traffic_seen |=> link_activity_indicator_out)
    else $error("activity low on idle link");

  a_speed_fast: assert property (
    link_up_in && link_speed_in == `SPEED_CODE_100
    |=> speed_indicator_green_out && !speed_indicator_yellow_out)
    else $error("wrong speed indication at 100");

  a_speed_giga: assert property (
    link_up_in && link_speed_in == `SPEED_CODE_1000
    |=> !speed_indicator_green_out && speed_indicator_yellow_out)
    else $error("wrong speed indication at 1000");

  a_speed_slow_off: assert property (
    !link_up_in || link_speed_in == `SPEED_CODE_10
    |=> !speed_indicator_green_out && !speed_indicator_yellow_out)
    else $error("speed indicator lit at 10 or no link");

  a_rst_min_low: assert property (
    $rose(reset_indication_n_out)
    |-> ind_low_len >= `CNT_W'(RST_MIN_CYCLES))
    else $error("reset indication low too briefly");

  a_sysrst_forces: assert property (
    system_reset_in_n_active |=> !reset_indication_n_out && !core_reset_n_out)
    else $error("system reset did not assert resets");

  a_held_until_rel: assert property (
    !system_reset_in_n_in [*3] |=> !core_reset_n_out)
    else $error("left reset while pin still low");

  a_sync_delay: assert property (
    !system_reset_in_n_in ##1 !system_reset_in_n_in |=> system_reset_in_n_active)
    else $error("synchroniser did not follow pin");

  a_kind_report: assert property (
    sys_released |=> reset_kind_valid_out &&
      (reset_kind_out == mezz_status_pkg::RESET_KIND_LONG) ==
      $past(hold_long))
    else $error("reset kind not reported on release");

  a_conf_flag: assert property (
    logic_configured_in |=> logic_configured_flag_out)
    else $error("configured flag missing");

  a_gpio_float: assert property (
    !logic_configured_in |=> &general_purpose_io_lines_oe_n_out)
    else $error("line driven before configuration");

  a_gpio_unused: assert property (
    1'b1 |=> (~general_purpose_io_lines_oe_n_out &
              ~$past(gpio_drive_use_in)) == '0)
    else $error("unused line driven");

  c_act_toggle: cover property (
    link_up_in && traffic_seen ##1 $changed(link_activity_indicator_out));
  c_rst_release: cover property ($rose(reset_indication_n_out));
  c_long_hold: cover property (
    sys_released && hold_long);
  c_gpio_drive: cover property (!general_purpose_io_lines_oe_n_out[0]);

endmodule

// file: verification/mezz_card_model.sv
`timescale 1ns/100ps

// ****************************************
// Card side of the connector
// ****************************************
module mezz_card_model #(
  parameter int unsigned MAX_HOLD = 500
) (
  // Clock
  input  wire logic        clk_sys_in,
  // Reset hold request
  input  wire logic        hold_req_in,
  input  wire logic [15:0] hold_len_in,
  // Board drive of the lines
  input  wire logic [95:0] drive_in,
  input  wire logic [95:0] oe_n_in,
  // Pins seen by the board
  output logic             system_reset_in_n_n_out,
  output logic [95:0]      level_out
);
  int unsigned left = 0;

  always @(posedge clk_sys_in) begin
    if (hold_req_in) begin
      left <= (hold_len_in > MAX_HOLD) ? MAX_HOLD : hold_len_in;
    end else if (left != 0) begin
      left <= left - 1;
    end
  end
  assign system_reset_in_n_n_out = (left == 0);

  // Pull-downs: an undriven line reads low, never the last value
  assign level_out = ~oe_n_in & drive_in;
endmodule

// file: verification/testbench.sv
`timescale 1ns/100ps

module testbench;
  localparam int unsigned RMIN = 20;
  localparam int unsigned BLINK = 8;
  localparam int unsigned LONG = 50;
  logic        clk_sys_in = 1'b0;
  logic        arst_n = 1'b0;
  logic        power_good = 1'b0;
  logic        link_up = 1'b0;
  logic        traffic = 1'b0;
  logic        configured = 1'b0;
  logic        hold_req = 1'b0;
  logic [1:0]  speed = 2'h0;
  logic [15:0] hold_len = 16'h0000;
  logic [95:0] drv_val = 96'h0;
  logic [95:0] drv_use = 96'h0;
  logic [95:0] level, gp_out, oe_n, sample;
  logic        act, grn, yel, rst_ind_n, core_n, kind_v, flag, system_reset_in_n_n;
  logic        prev;
  mezz_status_pkg::reset_kind_t kind, kind_seen;
  int          err_total = 0;
  int          n_tests = 0;
  int          kind_cnt = 0;
  int          n, toggles, k0;
  // Rows: link up, speed code, then activity, green, yellow
  logic [5:0]  rows [7] = '{6'h00, 6'h24, 6'h2e, 6'h35, 6'h08, 6'h10, 6'h3c};

  always #5 clk_sys_in = ~clk_sys_in;

  mezzanine_status_reset_signals #(
    .RST_MIN_CYCLES(RMIN), .BLINK_CYCLES(BLINK), .LONG_HOLD_CYCLES(LONG)
  ) i_dut (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n),
    .power_good_in(power_good), .system_reset_in_n_in(system_reset_in_n_n),
    .link_up_in(link_up), .link_traffic_in(traffic),
    .link_speed_in(speed), .logic_configured_in(configured),
    .gpio_drive_value_in(drv_val), .gpio_drive_use_in(drv_use),
    .general_purpose_io_lines_in(level),
    .link_activity_indicator_out(act), .speed_indicator_green_out(grn),
    .speed_indicator_yellow_out(yel), .reset_indication_n_out(rst_ind_n),
    .core_reset_n_out(core_n), .reset_kind_out(kind),
    .reset_kind_valid_out(kind_v), .logic_configured_flag_out(flag),
    .general_purpose_io_lines_out(gp_out),
    .general_purpose_io_lines_oe_n_out(oe_n), .gpio_sample_out(sample));

  mezz_card_model i_card (
    .clk_sys_in(clk_sys_in), .hold_req_in(hold_req),
    .hold_len_in(hold_len), .drive_in(gp_out), .oe_n_in(oe_n),
    .system_reset_in_n_n_out(system_reset_in_n_n), .level_out(level));

  always @(posedge clk_sys_in) begin
    if (kind_v === 1'b1) begin
      kind_seen <= kind;
      kind_cnt <= kind_cnt + 1;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic tick(input int cnt);
    repeat (cnt) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic ok(input logic c);
    check({95'h0, c}, {95'h0, 1'b1});
  endtask

  task automatic pin(input int len);
    hold_len = 16'(len);
    hold_req = 1'b1;
    tick(1);
    hold_req = 1'b0;
  endtask

  // Counts low cycles of the reset indication from the first low cycle seen after the call
  task automatic measure_low(output int cnt);
    cnt = 0;
    repeat (10) if (rst_ind_n !== 1'b0) tick(1);
    check(oe_n, {96{1'b1}});
    ok(core_n === 1'b0);
    while (rst_ind_n === 1'b0 && cnt < 2000) begin
      tick(1);
      cnt++;
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    tick(4);
    check({92'h0, rst_ind_n, core_n, flag, kind_v}, 96'h0);
    power_good = 1'b1;
    arst_n = 1'b1;
    measure_low(n);
    ok(n >= RMIN);
    for (int i = 0; i < 7; i++) begin
      {link_up, speed} = rows[i][5:3];
      tick(2);
      check({93'h0, act, grn, yel}, {93'h0, rows[i][2:0]});
    end
    link_up = 1'b1;
    traffic = 1'b1;
    toggles = 0;
    prev = act;
    for (int i = 0; i < 4 * BLINK; i++) begin
      tick(1);
      toggles += int'(act !== prev);
      prev = act;
    end
    ok(toggles >= 3);
    traffic = 1'b0;
    tick(3 * BLINK);
    ok(act === 1'b1);
    drv_val = 96'h5a5a_c3c3_0ff0_1234_8765_a5a5;
    drv_use = {96{1'b1}};
    tick(2);
    check(oe_n, {96{1'b1}});
    check(level, 96'h0);
    ok(flag === 1'b0);
    configured = 1'b1;
    drv_use = 96'h0000_ffff_0000_ffff_0f0f_3c3c;
    tick(2);
    check(oe_n, ~drv_use);
    ok(flag === 1'b1);
    check(gp_out, drv_val);
    tick(1);
    check(sample, drv_val & drv_use);
    k0 = kind_cnt;
    pin(10);
    measure_low(n);
    ok(n >= RMIN);
    ok(kind_cnt == k0 + 1 &&
       kind_seen === mezz_status_pkg::RESET_KIND_SHORT);
    tick(2);
    check(oe_n, ~drv_use);
    k0 = kind_cnt;
    pin(LONG + 10);
    measure_low(n);
    ok(n >= RMIN);
    ok(kind_cnt == k0 + 1 &&
       kind_seen === mezz_status_pkg::RESET_KIND_LONG);
    power_good = 1'b0;
    tick(5);
    ok(rst_ind_n === 1'b0);
    power_good = 1'b1;
    measure_low(n);
    ok(n + 5 >= RMIN && rst_ind_n === 1'b1);
    arst_n = 1'b0;
    pin(40);
    arst_n = 1'b1;
    tick(25);
    ok(rst_ind_n === 1'b0 && core_n === 1'b0);
    measure_low(n);
    ok(rst_ind_n === 1'b1);
    test_done;
  end

  // Whole run is under a thousand cycles; allow ample margin
  initial begin
    #50000;
    err_total++;
    test_done;
  end
endmodule
